// ===== core/eep_pkg.sv
// constants, types and helpers shared by both ends of the serial memory link
package eep_pkg;

	// ******************************
	// timing
	// ******************************
	localparam int EEP_CLK_MHZ      = 250;
	localparam int EEP_SK_PERIOD_NS = 80;
	localparam int EEP_SK_HALF_CYC  = EEP_SK_PERIOD_NS * EEP_CLK_MHZ / 2000;
	localparam int EEP_T_CS_NS      = 250;
	localparam int EEP_CS_GAP_CYC   = (EEP_T_CS_NS * EEP_CLK_MHZ + 999) / 1000;
	localparam int EEP_T_PROG_MS    = 10;
	localparam int EEP_PROG_CYC     = EEP_T_PROG_MS * EEP_CLK_MHZ * 1000;
	localparam int EEP_POLL_WAIT    = 16;

	// ******************************
	// framing and codes
	// ******************************
	localparam int         EEP_HDR_BITS   = 16;
	localparam int         EEP_FRAME_BITS = 32;
	localparam int         EEP_WORDS      = 256;
	localparam logic [3:0] EEP_START      = 4'ha;
	localparam logic [3:0] EEP_OP_READ    = 4'h8;
	localparam logic [3:0] EEP_OP_WRITE   = 4'h4;
	localparam logic [3:0] EEP_OP_WEN     = 4'h3;
	localparam logic [3:0] EEP_OP_WDS     = 4'h0;
	localparam logic [15:0] EEP_ERASED    = 16'hffff;
	localparam logic [15:0] EEP_ABORT_WORD = 16'h0000;

	// ******************************
	// host queue
	// ******************************
	localparam int EEP_FIFO_DEPTH = 16;
	localparam int EEP_FIFO_W     = 26;

	typedef enum logic [1:0] {
		EEP_CMD_READ  = 2'b00,
		EEP_CMD_WRITE = 2'b01,
		EEP_CMD_WEN   = 2'b10,
		EEP_CMD_WDS   = 2'b11
	} eep_cmd_t;

	// first-sent bit of a printed nibble lands in bit 0
	function automatic logic [3:0] eep_rev4(input logic [3:0] v);
		return {v[0], v[1], v[2], v[3]};
	endfunction : eep_rev4

endpackage : eep_pkg

// ===== core/eep_link_if.sv
// pins between the host port and the serial memory
`timescale 1ns/1ns
interface eep_link_if;
	logic chip_sel_n;
	logic serial_clock_in;
	logic serial_data_in;
	logic write_control_n;
	logic serial_data_out;
	logic serial_data_out_oe;
	logic ready_busy;
	logic data_line;

	// released output line reads high
	assign data_line = serial_data_out_oe ? serial_data_out : 1'b1;

	modport dev (
		input  chip_sel_n,
		input  serial_clock_in,
		input  serial_data_in,
		input  write_control_n,
		output serial_data_out,
		output serial_data_out_oe,
		output ready_busy
	);

	modport host (
		output chip_sel_n,
		output serial_clock_in,
		output serial_data_in,
		output write_control_n,
		input  data_line,
		input  ready_busy
	);
endinterface : eep_link_if

// ===== core/eep_fifo.sv
// command queue with registered ready and valid flags
`timescale 1ns/1ns
module eep_fifo #(
	parameter int WIDTH = eep_pkg::EEP_FIFO_W,
	parameter int DEPTH = eep_pkg::EEP_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	import eep_pkg::*;

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             push;
	logic             pop;

	assign push     = in_valid & in_ready;
	assign pop      = out_valid & out_ready;
	assign out_data = mem_q[rd_q];

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_q      <= '0;
			rd_q      <= '0;
			cnt_q     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q     <= cnt_d;
			in_ready  <= cnt_d != (AW+1)'(DEPTH);
			out_valid <= cnt_d != '0;
		end
	end
endmodule : eep_fifo

// ===== core/eep_host.sv
// host end: queues commands and shifts them out on the serial pins
`timescale 1ns/1ns
module eep_host (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	// command queue
	input  wire logic                cmd_valid,
	output logic                     cmd_ready,
	input  wire eep_pkg::eep_cmd_t   cmd_op,
	input  wire logic [7:0]          cmd_addr,
	input  wire logic [15:0]         cmd_wdata,
	// write protect level
	input  wire logic                wp_req,
	// read answer and status
	output logic                     rsp_valid,
	output logic [15:0]              rsp_data,
	output logic                     link_busy,
	// link
	eep_link_if.host                 link
);
	import eep_pkg::*;

	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_GAP   = 3'b001,
		H_SHIFT = 3'b010,
		H_POLL  = 3'b011
	} eep_hst_t;

	eep_hst_t  st_q;
	logic      f_valid;
	logic [EEP_FIFO_W-1:0] f_data;
	eep_cmd_t  f_op;
	eep_cmd_t  op_q;
	logic [31:0] tx_q;
	logic [31:0] frame;
	logic [3:0]  opc;
	logic [15:0] rx_q;
	logic [15:0] rx_n;
	logic [5:0]  cnt_q;
	logic [6:0]  tmr_q;
	logic        poll_q;
	logic        cs_q;
	logic        sk_q;
	logic        di_q;
	logic        wc_q;
	logic [2:0]  dsync_q;
	logic        do_f_q;

	// ******************************
	// command queue
	// ******************************
	eep_fifo #(.WIDTH(EEP_FIFO_W), .DEPTH(EEP_FIFO_DEPTH)) u_fifo (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (cmd_valid),
		.in_ready  (cmd_ready),
		.in_data   ({cmd_op, cmd_addr, cmd_wdata}),
		.out_valid (f_valid),
		.out_ready (st_q == H_IDLE),
		.out_data  (f_data)
	);

	assign f_op = eep_cmd_t'(f_data[25:24]);

	// ******************************
	// frame build, lsb first
	// ******************************
	always_comb begin
		case (f_op)
			EEP_CMD_READ:  opc = EEP_OP_READ;
			EEP_CMD_WRITE: opc = EEP_OP_WRITE;
			EEP_CMD_WEN:   opc = EEP_OP_WEN;
			default:       opc = EEP_OP_WDS;
		endcase
	end
	assign frame = {f_data[15:0], f_data[23:16],
		eep_rev4(opc), eep_rev4(EEP_START)};
	assign rx_n  = {do_f_q, rx_q[15:1]};

	// ******************************
	// returned data line sync
	// ******************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dsync_q <= 3'h7;
			do_f_q  <= 1'b1;
		end else begin
			dsync_q <= {dsync_q[1:0], link.data_line};
			if (dsync_q[2] == dsync_q[1]) begin
				do_f_q <= dsync_q[2];
			end
		end
	end

	// ******************************
	// sequencer
	// ******************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_q      <= H_IDLE;
			cs_q      <= 1'b1;
			sk_q      <= 1'b0;
			di_q      <= 1'b0;
			tx_q      <= '0;
			op_q      <= EEP_CMD_READ;
			rx_q      <= '0;
			cnt_q     <= '0;
			tmr_q     <= '0;
			poll_q    <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data  <= '0;
		end else begin
			rsp_valid <= 1'b0;
			case (st_q)
				H_IDLE: begin
					if (f_valid) begin
						tx_q  <= frame;
						op_q  <= f_op;
						tmr_q <= '0;
						st_q  <= H_GAP;
					end
				end
				H_GAP: begin
					if (tmr_q == 7'(EEP_CS_GAP_CYC - 1)) begin
						cs_q  <= 1'b0;
						tmr_q <= '0;
						cnt_q <= '0;
						if (poll_q) begin
							di_q <= 1'b1;
							st_q <= H_POLL;
						end else begin
							di_q <= tx_q[0];
							st_q <= H_SHIFT;
						end
					end else begin
						tmr_q <= tmr_q + 1'b1;
					end
				end
				H_SHIFT: begin
					if (tmr_q == 7'(EEP_SK_HALF_CYC - 1)) begin
						tmr_q <= '0;
						sk_q  <= ~sk_q;
						if (!sk_q) begin
							cnt_q <= cnt_q + 1'b1;
						end else begin
							// change data on the falling edge
							if (cnt_q > 6'(EEP_HDR_BITS)) begin
								rx_q <= rx_n;
							end
							if ((op_q == EEP_CMD_WEN || op_q == EEP_CMD_WDS)
								? cnt_q == 6'(EEP_HDR_BITS)
								: cnt_q == 6'(EEP_FRAME_BITS)) begin
								cs_q <= 1'b1;
								st_q <= (op_q == EEP_CMD_WRITE) ? H_GAP
									: H_IDLE;
								poll_q    <= op_q == EEP_CMD_WRITE;
								rsp_valid <= op_q == EEP_CMD_READ;
								rsp_data  <= rx_n;
							end else begin
								di_q <= tx_q[1];
								tx_q <= tx_q >> 1;
							end
						end
					end else begin
						tmr_q <= tmr_q + 1'b1;
					end
				end
				H_POLL: begin
					// clock stays low while select falls
					if (tmr_q != 7'(EEP_POLL_WAIT - 1)) begin
						tmr_q <= tmr_q + 1'b1;
					end else if (do_f_q) begin
						cs_q   <= 1'b1;
						poll_q <= 1'b0;
						st_q   <= H_IDLE;
					end
				end
				default: st_q <= H_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wc_q      <= 1'b1;
			link_busy <= 1'b0;
		end else begin
			wc_q      <= wp_req;
			link_busy <= st_q != H_IDLE;
		end
	end

	// separate data lines, never driven toward the memory output
	assign link.chip_sel_n      = cs_q;
	assign link.serial_clock_in = sk_q;
	assign link.serial_data_in  = di_q;
	assign link.write_control_n = wc_q;
endmodule : eep_host

// ===== core/eep_dev.sv
// memory end: decoder, word array, self-timed program cycle
`timescale 1ns/1ns
module eep_dev #(
	parameter int PROG_CYCLES = eep_pkg::EEP_PROG_CYC
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// link
	eep_link_if.dev   link,
	// state view
	output logic      wen_state,
	output logic      prog_busy
);
	import eep_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_HDR  = 3'b001,
		ST_RDAT = 3'b010,
		ST_WDAT = 3'b011,
		ST_STAT = 3'b100,
		ST_HOLD = 3'b101
	} eep_dst_t;

	eep_dst_t    st_q;
	logic [3:0]  raw;
	logic [3:0]  s1_q;
	logic [3:0]  s2_q;
	logic [3:0]  s3_q;
	logic [3:0]  flt_q;
	logic        cs_n;
	logic        sk;
	logic        di;
	logic        wc_n;
	logic        sk_prev_q;
	logic        cs_prev_q;
	logic        rise;
	logic        fall;
	logic        cs_fall;
	logic [15:0] sh_q;
	logic [15:0] sh_n;
	logic [3:0]  cnt_q;
	logic [3:0]  opc;
	logic        start_ok;
	logic        hdr_done;
	logic        wr_done;
	logic        armed_q;
	logic [7:0]  addr_q;
	logic [3:0]  rcnt_q;
	logic [15:0] rsh_q;
	logic [15:0] word;
	logic [15:0] mem_q [EEP_WORDS];
	logic [21:0] tmr_q;
	logic [7:0]  paddr_q;
	logic [15:0] pdata_q;
	logic        p_fin;
	logic        p_abort;
	logic        do_q;
	logic        oe_q;
	logic        rdy_q;

	// ******************************
	// pin synchronisers
	// ******************************
	assign raw = {link.chip_sel_n, link.serial_clock_in,
		link.serial_data_in, link.write_control_n};

	generate
		for (genvar i = 0; i < 4; i++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					s1_q[i]  <= (i == 3 || i == 0);
					s2_q[i]  <= (i == 3 || i == 0);
					s3_q[i]  <= (i == 3 || i == 0);
					flt_q[i] <= (i == 3 || i == 0);
				end else begin
					s1_q[i] <= raw[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					if (s2_q[i] == s3_q[i]) begin
						flt_q[i] <= s3_q[i];
					end
				end
			end
		end
	endgenerate

	assign cs_n = flt_q[3];
	assign sk   = flt_q[2];
	assign di   = flt_q[1];
	assign wc_n = flt_q[0];

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sk_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else begin
			sk_prev_q <= sk;
			cs_prev_q <= cs_n;
		end
	end

	assign rise    = sk & ~sk_prev_q;
	assign fall    = ~sk & sk_prev_q;
	assign cs_fall = ~cs_n & cs_prev_q;

	// ******************************
	// decode
	// ******************************
	assign sh_n     = {di, sh_q[15:1]};
	assign start_ok = eep_rev4(sh_n[3:0]) == EEP_START;
	assign opc      = eep_rev4(sh_n[7:4]);
	assign hdr_done = st_q == ST_HDR && rise && cnt_q == 4'hf;
	assign wr_done  = st_q == ST_WDAT && rise && cnt_q == 4'hf && !wc_n;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
		end else if (cs_n) begin
			st_q <= ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (cs_fall) begin
						if (armed_q && !sk) begin
							st_q <= ST_STAT;
						end else if (prog_busy) begin
							st_q <= ST_HOLD;
						end else begin
							st_q <= ST_HDR;
						end
					end
				end
				ST_HDR: begin
					if (hdr_done) begin
						if (!start_ok) begin
							st_q <= ST_HOLD;
						end else if (opc == EEP_OP_READ) begin
							st_q <= ST_RDAT;
						end else if (opc == EEP_OP_WRITE) begin
							st_q <= ST_WDAT;
						end else begin
							st_q <= ST_HOLD;
						end
					end
				end
				ST_WDAT: begin
					if (wc_n || (rise && cnt_q == 4'hf)) begin
						st_q <= ST_HOLD;
					end
				end
				ST_RDAT: st_q <= ST_RDAT;
				ST_STAT: st_q <= ST_STAT;
				ST_HOLD: st_q <= ST_HOLD;
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sh_q  <= '0;
			cnt_q <= '0;
		end else if (cs_fall) begin
			cnt_q <= '0;
		end else if ((st_q == ST_HDR || st_q == ST_WDAT) && rise) begin
			sh_q  <= sh_n;
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// enable latch; address bits are don't care
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wen_state <= 1'b0;
		end else if (hdr_done && start_ok) begin
			if (opc == EEP_OP_WEN) begin
				wen_state <= 1'b1;
			end else if (opc == EEP_OP_WDS) begin
				wen_state <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			armed_q <= 1'b0;
		end else if (wr_done) begin
			armed_q <= 1'b1;
		end else if (st_q == ST_STAT && !prog_busy) begin
			armed_q <= 1'b0;
		end
	end

	// ******************************
	// sequential read
	// ******************************
	assign word = mem_q[addr_q];

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			addr_q <= '0;
			rcnt_q <= '0;
			rsh_q  <= '0;
		end else if (hdr_done) begin
			addr_q <= sh_n[15:8];
			rcnt_q <= '0;
		end else if (st_q == ST_RDAT && !cs_n && fall) begin
			rcnt_q <= rcnt_q + 1'b1;
			if (rcnt_q == 4'h0) begin
				rsh_q  <= word >> 1;
				addr_q <= addr_q + 1'b1;
			end else begin
				rsh_q <= rsh_q >> 1;
			end
		end
	end

	// ******************************
	// program cycle
	// ******************************
	assign p_abort = prog_busy && wc_n;
	assign p_fin   = prog_busy && !wc_n && tmr_q == 22'(PROG_CYCLES - 1);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prog_busy <= 1'b0;
			tmr_q     <= '0;
			paddr_q   <= '0;
			pdata_q   <= '0;
		end else if (prog_busy) begin
			// select level has no effect here
			tmr_q <= tmr_q + 1'b1;
			if (p_abort || p_fin) begin
				prog_busy <= 1'b0;
			end
		end else if (wr_done && wen_state) begin
			prog_busy <= 1'b1;
			tmr_q     <= '0;
			paddr_q   <= addr_q;
			pdata_q   <= sh_n;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < EEP_WORDS; i++) begin
				mem_q[i] <= EEP_ERASED;
			end
		end else if (p_fin) begin
			mem_q[paddr_q] <= pdata_q;
		end else if (p_abort) begin
			mem_q[paddr_q] <= EEP_ABORT_WORD;
		end
	end

	// ******************************
	// output pins
	// ******************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			do_q  <= 1'b1;
			oe_q  <= 1'b0;
			rdy_q <= 1'b1;
		end else begin
			rdy_q <= ~prog_busy;
			if (cs_n) begin
				oe_q <= 1'b0;
			end else if (st_q == ST_STAT) begin
				oe_q <= 1'b1;
				do_q <= ~prog_busy;
			end else if (st_q == ST_RDAT && fall) begin
				oe_q <= 1'b1;
				do_q <= (rcnt_q == 4'h0) ? word[0] : rsh_q[0];
			end
		end
	end

	assign link.serial_data_out    = do_q;
	assign link.serial_data_out_oe = oe_q;
	assign link.ready_busy         = rdy_q;
endmodule : eep_dev

// ===== testbench/eep_link_assertions.sv
// concurrent checks on the serial memory link pins
`timescale 1ns/1ns
module eep_link_assertions #(
	parameter int PROG_CYCLES = 200
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// host driven pins
	input wire logic chip_sel_n,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	input wire logic write_control_n,
	// memory driven pins
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe,
	input wire logic ready_busy,
	input wire logic data_line
);
	import eep_pkg::*;
	int hi_q;
	int busy_q;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// ******************************
	// helper counters
	// ******************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !chip_sel_n) begin
			hi_q <= '0;
		end else begin
			hi_q <= hi_q + 32'h0000_0001;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n || ready_busy) begin
			busy_q <= '0;
		end else begin
			busy_q <= busy_q + 32'h0000_0001;
		end
	end
	// ******************************
	// pin checks
	// ******************************
	AST_START_BIT: assert property (
		$fell(chip_sel_n) && ready_busy |-> serial_data_in)
		else $error("select fell without a leading one");
	AST_DO_ON_FALL: assert property (
		serial_data_out_oe && $changed(serial_data_out) |-> !serial_clock_in)
		else $error("data out moved while serial clock high");
	AST_OE_ON_FALL: assert property (
		$rose(serial_data_out_oe) |-> !serial_clock_in && !chip_sel_n)
		else $error("data out enabled at a wrong moment");
	AST_OE_OFF: assert property (
		chip_sel_n [*8] |-> !serial_data_out_oe)
		else $error("data out driven while deselected");
	AST_BUSY_START: assert property (
		$fell(ready_busy) |-> serial_clock_in && !chip_sel_n)
		else $error("busy began outside a clock high phase");
	AST_BUSY_LEN: assert property (
		$rose(ready_busy) |->
		busy_q >= PROG_CYCLES - 2 && busy_q <= PROG_CYCLES + 2)
		else $error("program cycle length wrong");
	AST_STATUS_LOW: assert property (
		(serial_data_out_oe && !ready_busy) [*4] ##1 !ready_busy
		|-> !$past(data_line))
		else $error("status not low while programming");
	AST_CS_GAP: assert property (
		$fell(chip_sel_n) |-> hi_q >= EEP_CS_GAP_CYC - 1)
		else $error("select high time too short");
endmodule : eep_link_assertions

// ===== testbench/tb_serial_eeprom_command_port.sv
// self-checking bench: host port and serial memory joined over the link
`timescale 1ns/1ns
module tb_serial_eeprom_command_port;
	import eep_pkg::*;
	localparam int PROG = 200;
	logic        ref_clk;
	logic        rst_n;
	logic        cmd_valid;
	logic        cmd_ready;
	eep_cmd_t    cmd_op;
	logic [7:0]  cmd_addr;
	logic [15:0] cmd_wdata;
	logic        wp_req;
	logic        rsp_valid;
	logic [15:0] rsp_data;
	logic        link_busy;
	logic        wen_state;
	logic        prog_busy;
	logic        wen_b;
	logic        prog_b;
	logic        b_cs;
	logic        b_sk;
	logic        b_di;
	logic        b_wc;
	logic [47:0] frm;
	logic [47:0] got;
	int          fcnt;
	logic        sk_q;
	int          err_total;
	int          check_count;
	// ******************************
	// structure
	// ******************************
	eep_link_if u_eep_link_if();
	eep_link_if u_eep_link_if_b();
	assign u_eep_link_if_b.chip_sel_n = b_cs;
	assign u_eep_link_if_b.serial_clock_in = b_sk;
	assign u_eep_link_if_b.serial_data_in = b_di;
	assign u_eep_link_if_b.write_control_n = b_wc;
	eep_host u_eep_host (.ref_clk(ref_clk), .rst_n(rst_n),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .wp_req(wp_req),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.link_busy(link_busy), .link(u_eep_link_if));
	eep_dev #(.PROG_CYCLES(PROG)) u_eep_dev (.ref_clk(ref_clk),
		.rst_n(rst_n), .link(u_eep_link_if), .wen_state(wen_state),
		.prog_busy(prog_busy));
	eep_dev #(.PROG_CYCLES(PROG)) u_eep_dev_b (.ref_clk(ref_clk),
		.rst_n(rst_n), .link(u_eep_link_if_b), .wen_state(wen_b),
		.prog_busy(prog_b));
	eep_link_assertions #(.PROG_CYCLES(PROG)) u_eep_link_assertions (
		.ref_clk(ref_clk), .rst_n(rst_n),
		.chip_sel_n(u_eep_link_if.chip_sel_n),
		.serial_clock_in(u_eep_link_if.serial_clock_in),
		.serial_data_in(u_eep_link_if.serial_data_in),
		.write_control_n(u_eep_link_if.write_control_n),
		.serial_data_out(u_eep_link_if.serial_data_out),
		.serial_data_out_oe(u_eep_link_if.serial_data_out_oe),
		.ready_busy(u_eep_link_if.ready_busy),
		.data_line(u_eep_link_if.data_line));
	// ******************************
	// clock, wire monitor, watchdog
	// ******************************
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		sk_q <= u_eep_link_if.serial_clock_in;
		if (u_eep_link_if.chip_sel_n !== 1'h0) begin
			fcnt <= 0;
		end else if (u_eep_link_if.serial_clock_in && !sk_q && fcnt < 48) begin
			frm[fcnt] <= u_eep_link_if.serial_data_in;
			fcnt <= fcnt + 1;
		end
	end
	initial begin
		#(4 * 90000);
		err_total++;
		$display("watchdog expired");
		tally_and_finish();
	end
	// ******************************
	// helpers
	// ******************************
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic logic [15:0] hdr(input logic [3:0] op,
		input logic [7:0] a);
		return {a, op[0], op[1], op[2], op[3], EEP_START[0], EEP_START[1],
			EEP_START[2], EEP_START[3]};
	endfunction : hdr
	task automatic cmd(input eep_cmd_t op, input logic [7:0] a,
		input logic [15:0] d);
		cmd_op <= op;
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_valid <= 1'h1;
		@(posedge ref_clk);
		for (int i = 0; i < 100 && cmd_ready !== 1'h1; i++) @(posedge ref_clk);
		cmd_valid <= 1'h0;
		@(posedge ref_clk);
	endtask : cmd
	task automatic settle();
		int quiet;
		quiet = 0;
		for (int i = 0; i < 5000 && quiet < 16; i++) begin
			@(posedge ref_clk);
			quiet = (link_busy !== 1'h0 || u_eep_link_if.ready_busy !== 1'h1)
				? 0 : quiet + 1;
		end
	endtask : settle
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		cmd(EEP_CMD_READ, a, 16'h0000);
		for (int i = 0; i < 2000 && rsp_valid !== 1'h1; i++) @(posedge ref_clk);
		chk("read word", {16'h0, exp}, {16'h0, rsp_data});
		chk("read frame", {16'h0, hdr(EEP_OP_READ, a)}, {16'h0, frm[15:0]});
		settle();
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		cmd(EEP_CMD_WRITE, a, d);
		settle();
		chk("write frame", {d, hdr(EEP_OP_WRITE, a)}, frm[31:0]);
	endtask : wr
	task automatic frame_b(input logic [47:0] v, input int n);
		b_cs <= 1'h0;
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < n; i++) begin
			b_di <= v[i];
			repeat (EEP_SK_HALF_CYC) @(posedge ref_clk);
			got[i] = u_eep_link_if_b.data_line;
			b_sk <= 1'h1;
			repeat (EEP_SK_HALF_CYC) @(posedge ref_clk);
			b_sk <= 1'h0;
		end
		repeat (EEP_SK_HALF_CYC) @(posedge ref_clk);
		b_cs <= 1'h1;
		b_di <= ~v[n-1];
		repeat (EEP_CS_GAP_CYC + 8) @(posedge ref_clk);
	endtask : frame_b
	task automatic poll_b(input logic exp);
		b_cs <= 1'h0;
		repeat (16) @(posedge ref_clk);
		chk("status line", {31'h0, exp}, {31'h0, u_eep_link_if_b.data_line});
		b_cs <= 1'h1;
		repeat (EEP_CS_GAP_CYC + 8) @(posedge ref_clk);
	endtask : poll_b
	// ******************************
	// scenarios
	// ******************************
	task automatic t_reset();
		chk("enable latch", 32'h0, {31'h0, wen_state});
		chk("ready pin", 32'h1, {31'h0, u_eep_link_if.ready_busy});
		chk("oe", 32'h0, {31'h0, u_eep_link_if.serial_data_out_oe});
		$display("done reset");
	endtask : t_reset
	task automatic t_protect();
		wr(8'h10, 16'h1111);
		rd(8'h10, 16'hffff);
		wp_req <= 1'h1;
		cmd(EEP_CMD_WEN, 8'h5a, 16'h0000);
		settle();
		chk("enable frame", {16'h0, hdr(EEP_OP_WEN, 8'h5a)}, {16'h0, frm[15:0]});
		chk("enable latch", 32'h1, {31'h0, wen_state});
		wr(8'h10, 16'h2222);
		rd(8'h10, 16'hffff);
		wp_req <= 1'h0;
		$display("done protect");
	endtask : t_protect
	task automatic t_write_read();
		cmd(EEP_CMD_WRITE, 8'hff, 16'h1234);
		cmd(EEP_CMD_WRITE, 8'h00, 16'habcd);
		settle();
		rd(8'hff, 16'h1234);
		rd(8'h00, 16'habcd);
		$display("done write read");
	endtask : t_write_read
	task automatic t_fifo();
		logic [7:0] q[$];
		cmd_op <= EEP_CMD_READ;
		cmd_addr <= 8'h00;
		cmd_valid <= 1'h1;
		for (int i = 0; i < 60; i++) begin
			@(posedge ref_clk);
			if (cmd_ready !== 1'h1) break;
			q.push_back(cmd_addr);
			cmd_addr <= ~cmd_addr;
		end
		cmd_valid <= 1'h0;
		chk("queue refused", 32'h1, {31'h0, q.size() >= EEP_FIFO_DEPTH});
		while (q.size() > 0) begin
			for (int i = 0; i < 2000 && rsp_valid !== 1'h1; i++) @(posedge ref_clk);
			chk("queued read", {16'h0, q[0] == 8'hff ? 16'h1234 : 16'habcd},
				{16'h0, rsp_data});
			void'(q.pop_front());
			@(posedge ref_clk);
		end
		settle();
		chk("queue empty", 32'h1, {31'h0, cmd_ready});
		$display("done fifo");
	endtask : t_fifo
	task automatic t_disable();
		cmd(EEP_CMD_WDS, 8'h00, 16'h0000);
		settle();
		chk("disable frame", {16'h0, hdr(EEP_OP_WDS, 8'h00)}, {16'h0, frm[15:0]});
		chk("enable latch", 32'h0, {31'h0, wen_state});
		wr(8'h00, 16'h5555);
		rd(8'h00, 16'habcd);
		$display("done disable");
	endtask : t_disable
	task automatic t_b_enable();
		frame_b({16'h0, hdr(EEP_OP_WDS, 8'h00), hdr(EEP_OP_WEN, 8'hc3)}, 32);
		chk("enable latch b", 32'h1, {31'h0, wen_b});
		$display("done enable b");
	endtask : t_b_enable
	task automatic t_b_cancel();
		frame_b({16'h0, 16'h5555, hdr(EEP_OP_WRITE, 8'h03)}, 20);
		chk("no program", 32'h0, {31'h0, prog_b});
		frame_b({32'h0, hdr(EEP_OP_READ, 8'h03)}, 32);
		chk("kept word", 32'hffff, {16'h0, got[31:16]});
		$display("done cancel b");
	endtask : t_b_cancel
	task automatic t_b_abort();
		frame_b({16'h0, 16'h1234, hdr(EEP_OP_WRITE, 8'h03)}, 32);
		chk("program on", 32'h1, {31'h0, prog_b});
		b_wc <= 1'h1;
		repeat (4) @(posedge ref_clk);
		b_wc <= 1'h0;
		repeat (8) @(posedge ref_clk);
		chk("program off", 32'h0, {31'h0, prog_b});
		poll_b(1'h1);
		frame_b({32'h0, hdr(EEP_OP_READ, 8'h03)}, 32);
		chk("aborted word", {16'h0, EEP_ABORT_WORD}, {16'h0, got[31:16]});
		$display("done abort b");
	endtask : t_b_abort
	task automatic t_b_status();
		frame_b({16'h0, 16'h00ff, hdr(EEP_OP_WRITE, 8'h02)}, 32);
		poll_b(1'h0);
		for (int i = 0; i < 400 && prog_b !== 1'h0; i++) @(posedge ref_clk);
		poll_b(1'h1);
		frame_b({32'h0, hdr(EEP_OP_READ, 8'h02)}, 48);
		chk("first word", 32'h00ff, {16'h0, got[31:16]});
		chk("next word", {16'h0, EEP_ABORT_WORD}, {16'h0, got[47:32]});
		$display("done status b");
	endtask : t_b_status
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		ref_clk = 1'h0;
		rst_n = 1'h0;
		cmd_valid = 1'h0;
		cmd_op = EEP_CMD_READ;
		cmd_addr = 8'h00;
		cmd_wdata = 16'h0000;
		wp_req = 1'h0;
		b_cs = 1'h1;
		b_sk = 1'h0;
		b_di = 1'h0;
		b_wc = 1'h0;
		err_total = 0;
		check_count = 0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge ref_clk);
		t_reset();
		t_protect();
		t_write_read();
		t_fifo();
		t_disable();
		t_b_enable();
		t_b_cancel();
		t_b_abort();
		t_b_status();
		tally_and_finish();
	end
endmodule : tb_serial_eeprom_command_port
